// ==== logic/pcs_pkg.sv ====
package pcs_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_PLL_CONTROL = 8'h36;
  localparam logic [7:0] IDX_PLL_BANDWIDTH_CONTROL = 8'h37;
  localparam logic [7:0] IDX_FEEDBACK_MULTIPLIER_HIGH = 8'h38;
  localparam logic [7:0] IDX_FEEDBACK_MULTIPLIER_LOW = 8'h39;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // pll_control
  localparam int CTL_IRQ_EN_POS = 7;
  localparam int CTL_FLAG_POS = 6;
  localparam int CTL_LOOP_EN_POS = 5;
  localparam int CTL_BCS_POS = 4;
  localparam int CTL_PRE_LSB = 2;
  localparam int CTL_VPR_LSB = 0;
  // pll_bandwidth_control
  localparam int BWC_AUTO_POS = 7;
  localparam int BWC_LOCK_POS = 6;
  localparam int BWC_ACQ_POS = 5;
  // feedback multiplier split
  localparam int MULT_HIGH_W = 4;

  // ****************************************************************
  // reset values and zero-multiplier substitute
  // ****************************************************************
  localparam logic RST_LOOP_ENABLE = 1'b1;
  localparam logic [11:0] RST_FEEDBACK_MULT = 12'h040;
  localparam logic [11:0] MULT_ZERO_SUBST = 12'h001;

  // ****************************************************************
  // timing counts
  // ****************************************************************
  // source edges to wait on each clock before the base clock switches
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  // ****************************************************************
  // configuration carried to the analog loop
  // ****************************************************************
  typedef struct packed {
    logic loopEnable;
    logic [1:0] prescaleExp;
    logic [1:0] vcoRangeExp;
    logic autoMode;
    logic manualTrack;
    logic [11:0] feedbackMult;
  } pcs_loop_cfg_t;

endpackage

// ==== logic/pcs_pll_ctrl.sv ====
`timescale 1ns/1ps
// What this block does
// - lock irq only when enable set, auto-gated
// - flag sets on every lock toggle in auto mode
// - flag reads zero in manual mode
// - any control register read clears flag, unless a lock toggle sets it that cycle
// - loop enable cannot clear while bcs set
// - reset: loop enabled, bcs clear
// - bcs picks vco or crystal, halved
// - bcs cannot set while loop off
// - switch within three edges each, output static
// - prescaler exponent locked while loop on
// - vco range exponent locked while loop on
// - auto bit selects bandwidth mode, reset manual
// - lock bit reads status in auto, else zero
// - track bit: status in auto, forced in manual
// - manual track value kept during auto
// - twelve-bit multiplier, zero behaves as one
// - multiplier resets to sixty-four
// - multiplier writes blocked while loop on
// - high multiplier upper nibble reads zero
module pcs_pll_ctrl
  import pcs_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog loop side
  input wire logic pllLocked,
  input wire logic pllTracking,
  input wire logic crystalClock,
  input wire logic vcoClock,
  output pcs_loop_cfg_t loopCfg,
  output logic baseClockOut,
  output logic lockChangeIrq
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  // any eight-bit index times four must fit the address bus
  if (ADDR_W < 10)
  begin : gBadAddr
    $error("pcs_pll_ctrl: ADDR_W must be at least 10");
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // byte address of a register index
  function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
    regAddr = ADDR_W'({idx, 2'b00});
  endfunction

  // ****************************************************************
  // register state
  // ****************************************************************
  logic irqEnable_reg; // lock-change interrupt enable
  logic lockFlag_reg; // sticky lock-change flag
  logic loopEnable_reg; // loop on
  logic baseSel_reg; // base clock select, 1 = vco
  logic [1:0] prescale_reg; // prescaler exponent
  logic [1:0] vcoRange_reg; // vco range exponent
  logic autoMode_reg; // automatic bandwidth
  logic acqManual_reg; // hidden manual track value
  logic lockSeen_reg; // lock indicator as seen in auto mode
  logic [11:0] mult_reg; // feedback multiplier
  logic [31:0] rdData_next; // read mux

  // bus phases
  logic accessCyc;
  logic wrDone;
  logic rdDone;
  logic hitCtl;
  logic hitBwc;
  logic hitHigh;
  logic hitLow;
  logic hitAny;
  logic laneLow;
  logic [7:0] wrByte;

  assign accessCyc = psel & penable;
  // writes and reads take effect at the edge where pready is sampled high
  assign wrDone = accessCyc & pready & pwrite;
  assign rdDone = accessCyc & pready & ~pwrite;
  assign laneLow = pstrb[0];
  assign wrByte = pwdata[7:0];

  // address decode
  always_comb
  begin
    hitCtl = 1'b0;
    hitBwc = 1'b0;
    hitHigh = 1'b0;
    hitLow = 1'b0;
    if (paddr == regAddr(IDX_PLL_CONTROL))
      hitCtl = 1'b1;
    else if (paddr == regAddr(IDX_PLL_BANDWIDTH_CONTROL))
      hitBwc = 1'b1;
    else if (paddr == regAddr(IDX_FEEDBACK_MULTIPLIER_HIGH))
      hitHigh = 1'b1;
    else if (paddr == regAddr(IDX_FEEDBACK_MULTIPLIER_LOW))
      hitLow = 1'b1;
  end
  assign hitAny = hitCtl | hitBwc | hitHigh | hitLow;

  // ****************************************************************
  // apb handshake
  // ****************************************************************
  // one wait state so read data and pready come straight from flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      pready <= accessCyc & ~pready;
      // unmapped addresses answer with an error and zero data
      pslverr <= accessCyc & ~pready & ~hitAny;
      prdata <= rdData_next;
    end
  end

  // read mux, reserved and unimplemented bits as zero
  always_comb
  begin
    rdData_next = 32'h0000_0000;
    if (hitCtl)
    begin
      rdData_next[CTL_IRQ_EN_POS] = irqEnable_reg & autoMode_reg;
      rdData_next[CTL_FLAG_POS] = lockFlag_reg & autoMode_reg;
      rdData_next[CTL_LOOP_EN_POS] = loopEnable_reg;
      rdData_next[CTL_BCS_POS] = baseSel_reg;
      rdData_next[CTL_PRE_LSB +: 2] = prescale_reg;
      rdData_next[CTL_VPR_LSB +: 2] = vcoRange_reg;
    end
    else if (hitBwc)
    begin
      rdData_next[BWC_AUTO_POS] = autoMode_reg;
      rdData_next[BWC_LOCK_POS] = lockSeen_reg & autoMode_reg;
      // status in auto, stored value in manual
      rdData_next[BWC_ACQ_POS] = autoMode_reg ? pllTracking : acqManual_reg;
    end
    else if (hitHigh)
      rdData_next[MULT_HIGH_W-1:0] = mult_reg[11:8];
    else if (hitLow)
      rdData_next[7:0] = mult_reg[7:0];
  end

  // ****************************************************************
  // pll control register
  // ****************************************************************
  // interrupt enable, only writable in auto mode
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irqEnable_reg <= 1'b0;
    else if (clkEn)
    begin
      if (!autoMode_reg)
        irqEnable_reg <= 1'b0;
      else if (wrDone && hitCtl && laneLow)
        irqEnable_reg <= wrByte[CTL_IRQ_EN_POS];
    end
  end

  // loop enable and base select interlock: each checks the other's
  // current value, so one write can clear loop enable and set bcs together
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopEnable_reg <= RST_LOOP_ENABLE;
      baseSel_reg <= 1'b0;
    end
    else if (clkEn && wrDone && hitCtl && laneLow)
    begin
      if (!baseSel_reg)
        loopEnable_reg <= wrByte[CTL_LOOP_EN_POS];
      if (loopEnable_reg || !wrByte[CTL_BCS_POS])
        baseSel_reg <= wrByte[CTL_BCS_POS];
    end
  end

  // exponent fields, frozen while the loop runs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_reg <= 2'h0;
      vcoRange_reg <= 2'h0;
    end
    else if (clkEn && wrDone && hitCtl && laneLow && !loopEnable_reg)
    begin
      prescale_reg <= wrByte[CTL_PRE_LSB +: 2];
      vcoRange_reg <= wrByte[CTL_VPR_LSB +: 2];
    end
  end

  // lock history and sticky flag
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockSeen_reg <= 1'b0;
      lockFlag_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      lockSeen_reg <= pllLocked & autoMode_reg;
      // set on toggle, wins over read clear
      if (autoMode_reg && (pllLocked != lockSeen_reg))
        lockFlag_reg <= 1'b1;
      else if (rdDone && hitCtl)
        lockFlag_reg <= 1'b0;
      else if (!autoMode_reg)
        lockFlag_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // bandwidth control register
  // ****************************************************************
  // auto bit and hidden manual track value
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      autoMode_reg <= 1'b0;
      acqManual_reg <= 1'b0;
    end
    else if (clkEn && wrDone && hitBwc && laneLow)
    begin
      autoMode_reg <= wrByte[BWC_AUTO_POS];
      if (!autoMode_reg)
        acqManual_reg <= wrByte[BWC_ACQ_POS];
    end
  end

  // ****************************************************************
  // feedback multiplier
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mult_reg <= RST_FEEDBACK_MULT;
    else if (clkEn && wrDone && laneLow && !loopEnable_reg)
    begin
      if (hitHigh)
        mult_reg[11:8] <= wrByte[MULT_HIGH_W-1:0];
      else if (hitLow)
        mult_reg[7:0] <= wrByte;
    end
  end

  // ****************************************************************
  // outputs to the analog loop and interrupt
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopCfg <= '0;
      lockChangeIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      loopCfg.loopEnable <= loopEnable_reg;
      loopCfg.prescaleExp <= prescale_reg;
      loopCfg.vcoRangeExp <= vcoRange_reg;
      loopCfg.autoMode <= autoMode_reg;
      loopCfg.manualTrack <= acqManual_reg;
      loopCfg.feedbackMult <= (mult_reg == 12'h000) ? MULT_ZERO_SUBST : mult_reg;
      // request needs flag, enable and auto
      lockChangeIrq <= lockFlag_reg & irqEnable_reg & autoMode_reg;
    end
  end

  // ****************************************************************
  // base clock selector
  // ****************************************************************
  // source clocks are sampled as plain inputs; rising edges found here
  logic xtalPrev_reg;
  logic vcoPrev_reg;
  logic xtalRise;
  logic vcoRise;
  logic activeSel_reg; // source currently driving the output
  logic [1:0] xtalCnt_reg; // crystal edges seen during a switch
  logic [1:0] vcoCnt_reg; // vco edges seen during a switch
  logic switching;
  logic srcRise;

  assign xtalRise = crystalClock & ~xtalPrev_reg;
  assign vcoRise = vcoClock & ~vcoPrev_reg;
  assign switching = activeSel_reg != baseSel_reg;
  assign srcRise = activeSel_reg ? vcoRise : xtalRise;

  // edge history
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtalPrev_reg <= 1'b0;
      vcoPrev_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      xtalPrev_reg <= crystalClock;
      vcoPrev_reg <= vcoClock;
    end
  end

  // switch sequencer: output frozen until both sources showed three
  // edges (a stopped vco counts every cycle), trading a few cycles of latency for a glitch-free change
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      activeSel_reg <= 1'b0;
      xtalCnt_reg <= 2'h0;
      vcoCnt_reg <= 2'h0;
    end
    else if (clkEn)
    begin
      if (!switching)
      begin
        xtalCnt_reg <= 2'h0;
        vcoCnt_reg <= 2'h0;
      end
      else if (xtalCnt_reg == SWITCH_EDGES && vcoCnt_reg == SWITCH_EDGES)
        activeSel_reg <= baseSel_reg;
      else
      begin
        if (xtalRise && xtalCnt_reg != SWITCH_EDGES)
          xtalCnt_reg <= xtalCnt_reg + 2'h1;
        // a stopped vco counts as settled, or a switch back would hang
        if ((vcoRise || !loopEnable_reg) && vcoCnt_reg != SWITCH_EDGES)
          vcoCnt_reg <= vcoCnt_reg + 2'h1;
      end
    end
  end

  // halved output, held static while switching
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      baseClockOut <= 1'b0;
    else if (clkEn && !switching && srcRise)
      baseClockOut <= ~baseClockOut;
  end

endmodule

// ==== testbench/pcs_pll_ctrl_asserts.sv ====
`timescale 1ns/1ps
module pcs_pll_ctrl_asserts
  import pcs_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb answer
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // loop side
  input wire pcs_loop_cfg_t loopCfg,
  input wire logic lockChangeIrq
);
  // ****************************************************************
  // read decode
  // ****************************************************************
  // byte address is four times the index
  localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({IDX_PLL_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] A_BW = ADDR_W'({IDX_PLL_BANDWIDTH_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] A_HI = ADDR_W'({IDX_FEEDBACK_MULTIPLIER_HIGH, 2'b00});
  logic rdCtl;
  logic rdBw;
  logic rdHi;
  // paddr is held through the answer cycle, so it names the read
  assign rdCtl = pready && !pwrite && paddr == A_CTL;
  assign rdBw = pready && !pwrite && paddr == A_BW;
  assign rdHi = pready && !pwrite && paddr == A_HI;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_irq_auto;
    lockChangeIrq |-> loopCfg.autoMode;
  endproperty
  a_irq_auto: assert property (p_irq_auto)
    else $error("irq raised in manual mode");
  // config lags the registers one cycle, so $past gives the pre-write enable
  property p_pre_lock;
    $past(loopCfg.loopEnable) |-> $stable(loopCfg.prescaleExp);
  endproperty
  a_pre_lock: assert property (p_pre_lock)
    else $error("prescaler changed while loop on");
  property p_vpr_lock;
    $past(loopCfg.loopEnable) |-> $stable(loopCfg.vcoRangeExp);
  endproperty
  a_vpr_lock: assert property (p_vpr_lock)
    else $error("range exponent changed while loop on");
  property p_mult_lock;
    $past(loopCfg.loopEnable) |-> $stable(loopCfg.feedbackMult);
  endproperty
  a_mult_lock: assert property (p_mult_lock)
    else $error("multiplier changed while loop on");
  property p_mult_nz;
    $past(rst_n) |-> loopCfg.feedbackMult != 12'h000;
  endproperty
  a_mult_nz: assert property (p_mult_nz)
    else $error("divider shows zero");
  property p_high_nib;
    rdHi |-> prdata[7:4] == 4'h0;
  endproperty
  a_high_nib: assert property (p_high_nib)
    else $error("high multiplier upper nibble not zero");
  property p_lock_manual;
    rdBw && !loopCfg.autoMode |-> !prdata[BWC_LOCK_POS];
  endproperty
  a_lock_manual: assert property (p_lock_manual)
    else $error("lock bit set in manual mode");
  property p_flag_manual;
    rdCtl && !loopCfg.autoMode |-> prdata[CTL_IRQ_EN_POS:CTL_FLAG_POS] == 2'b00;
  endproperty
  a_flag_manual: assert property (p_flag_manual)
    else $error("flag or enable set in manual mode");
endmodule

bind pcs_pll_ctrl pcs_pll_ctrl_asserts #(.ADDR_W(ADDR_W)) pcs_pll_ctrl_asserts_i (.mclk, .rst_n,
  .pwrite, .paddr, .prdata, .pready, .loopCfg, .lockChangeIrq);

// ==== testbench/pcs_loop_model.sv ====
`timescale 1ns/1ps
module pcs_loop_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bench controls
  input wire logic lockReq,
  input wire logic loopOn,
  // analog loop outputs
  output logic pllLocked,
  output logic pllTracking,
  output logic crystalClock,
  output logic vcoClock
);
  logic [2:0] xCnt;
  logic [2:0] vCnt;
  // crystal runs free, period ten mclk
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) begin xCnt <= 3'h0; crystalClock <= 1'b0; end
    else if (xCnt == 3'h4) begin xCnt <= 3'h0; crystalClock <= ~crystalClock; end
    else xCnt <= xCnt + 3'h1;
  // vco stands still while the loop is off, period six mclk
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) begin vCnt <= 3'h0; vcoClock <= 1'b0; end
    else if (!loopOn) vCnt <= 3'h0;
    else if (vCnt == 3'h2) begin vCnt <= 3'h0; vcoClock <= ~vcoClock; end
    else vCnt <= vCnt + 3'h1;
  // lock only with the loop on; tracking follows lock a cycle late
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) begin pllLocked <= 1'b0; pllTracking <= 1'b0; end
    else begin pllLocked <= lockReq & loopOn; pllTracking <= pllLocked; end
endmodule

// ==== testbench/pcs_pll_ctrl_tb.sv ====
`timescale 1ns/1ps
module pcs_pll_ctrl_tb
  import pcs_pkg::*;
;
  localparam logic [11:0] A_CTL = {2'b00, IDX_PLL_CONTROL, 2'b00};
  localparam logic [11:0] A_BW = {2'b00, IDX_PLL_BANDWIDTH_CONTROL, 2'b00};
  localparam logic [11:0] A_HI = {2'b00, IDX_FEEDBACK_MULTIPLIER_HIGH, 2'b00};
  localparam logic [11:0] A_LO = {2'b00, IDX_FEEDBACK_MULTIPLIER_LOW, 2'b00};
  // ****************************************************************
  // signals
  // ****************************************************************
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, lockReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pllLocked, pllTracking, crystalClock, vcoClock, baseClockOut, lockChangeIrq;
  pcs_loop_cfg_t loopCfg;
  logic [33:0] expQ[$];  // bit 33 marks a read to check
  logic [33:0] ex;
  logic [31:0] r;
  logic [1:0] pre, vpr;
  int error_cnt, comparisons, cyc, seed;

  pcs_pll_ctrl #(.ADDR_W(12)) pcs_pll_ctrl_i (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pllLocked(pllLocked), .pllTracking(pllTracking), .crystalClock(crystalClock),
    .vcoClock(vcoClock), .loopCfg(loopCfg), .baseClockOut(baseClockOut),
    .lockChangeIrq(lockChangeIrq));
  pcs_loop_model pcs_loop_model_i (.mclk(mclk), .rst_n(rst_n), .lockReq(lockReq),
    .loopOn(loopCfg.loopEnable), .pllLocked(pllLocked), .pllTracking(pllTracking),
    .crystalClock(crystalClock), .vcoClock(vcoClock));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task stop_test();
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
    expQ.push_back({~w, e});
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench timeout ends this wait
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 33'h0_0000_0000);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b0, a, 8'h00, {25'h000_0000, d});
  endtask
  // base clock changes counted over 120 cycles
  task span(input int lo, input int hi);
    int n;
    logic prev;
    n = 0;
    prev = baseClockOut;
    repeat (120) begin @(posedge mclk); if (baseClockOut !== prev) n++; prev = baseClockOut; end
    cmp(33'h1, 33'(n >= lo && n <= hi));
  endtask

  // ****************************************************************
  // checking and clocks
  // ****************************************************************
  // read data taken at the rising edge where pready is sampled high
  always @(posedge mclk)
    if (pready === 1'b1)
    begin
      ex = expQ.pop_front();
      if (ex[33]) cmp(ex[32:0], {pslverr, prdata});
    end
  // hang guard, well above the few hundred cycles needed
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000) begin error_cnt++; stop_test(); end
  end
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    seed = 77512; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; lockReq = 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    span(11, 13);
    rd(A_CTL, 8'h20);
    rd(A_BW, 8'h00);
    rd(A_HI, 8'h00);
    rd(A_LO, 8'h40);
    xfer(1'b0, 12'h0E8, 8'h00, 33'h1_0000_0000);
    wr(A_LO, 8'h55);
    rd(A_LO, 8'h40);
    r = $random(seed);
    pre = r[3:2];
    vpr = {1'b0, r[0]};
    wr(A_CTL, 8'h00);
    wr(A_CTL, {4'h1, pre, vpr});
    rd(A_CTL, {4'h0, pre, vpr});
    wr(A_HI, 8'hFF);
    rd(A_HI, 8'h0F);
    wr(A_LO, r[15:8]);
    rd(A_LO, r[15:8]);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h00);
    wr(A_CTL, {4'h2, pre, vpr});
    wr(A_CTL, {4'h3, ~pre, vpr});
    rd(A_CTL, {4'h3, pre, vpr});
    wr(A_LO, 8'h77);
    rd(A_LO, 8'h00);
    cmp(33'h0_0000_0001, {21'h00_0000, loopCfg.feedbackMult});
    wr(A_CTL, {4'h1, pre, vpr});
    wr(A_CTL, {4'hB, pre, vpr});
    rd(A_CTL, {4'h3, pre, vpr});
    span(19, 21);
    wr(A_BW, 8'h20);
    rd(A_BW, 8'h20);
    wr(A_BW, 8'hA0);
    wr(A_CTL, {4'hB, pre, vpr});
    lockReq <= 1'b1;
    repeat (6) @(posedge mclk);
    cmp(33'h1, {32'h0000_0000, lockChangeIrq});
    rd(A_CTL, {4'hF, pre, vpr});
    rd(A_CTL, {4'hB, pre, vpr});
    cmp(33'h0, {32'h0000_0000, lockChangeIrq});
    rd(A_BW, 8'hE0);
    wr(A_CTL, {4'h3, pre, vpr});
    lockReq <= 1'b0;
    repeat (6) @(posedge mclk);
    cmp(33'h0, {32'h0000_0000, lockChangeIrq});
    rd(A_CTL, {4'h7, pre, vpr});
    wr(A_BW, 8'h00);
    rd(A_BW, 8'h20);
    rd(A_CTL, {4'h3, pre, vpr});
    lockReq <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(A_CTL, {4'h3, pre, vpr});
    rd(A_BW, 8'h20);
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule
